// ===== core/ptp_event_sample_slots_7_8.sv
/*
 * seventh and eighth event timestamp sample slots for two timestamp units,
 * read over an avalon-mm slave with waitrequest.
 * assumes capture strobes and the unit index come from core_clk logic.
 */
// Function
// - the slot registers shown are those of the unit picked by bit 8 of the unit index.
// - bit 30 of each nanoseconds register gives the edge polarity, one for rising.
// - bits 29 to 0 of each nanoseconds register hold the capture nanoseconds.
// - each seconds register holds all 32 bits of the capture seconds.
// - bits 2 to 0 of the seventh phase register give the 8ns sub-cycle in a 40ns period.
// - phase codes are 000, 001, 101, 011, 100 for 0, 8, 16, 24, 32 ns.
// - the eighth sample has its own nanoseconds and seconds register pair.
`timescale 1ns/1ps
`default_nettype none
module ptp_event_sample_slots_7_8
	import ts_slot_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [ts_slot_pkg::addr_w-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic [15:0] unit_index,
	input wire logic [ts_slot_pkg::num_units-1:0] capture7_strobe,
	input wire logic [ts_slot_pkg::num_units-1:0] capture8_strobe,
	input wire logic capture_polarity,
	input wire logic [ts_slot_pkg::nanos_w-1:0] capture_nanos,
	input wire logic [ts_slot_pkg::secs_w-1:0] capture_secs,
	input wire logic [ts_slot_pkg::phase_w-1:0] capture_phase
);
	import ts_slot_pkg::*;

	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h3;

	// which register an address picks
	typedef enum {
		reg_ns7,
		reg_s7,
		reg_ph7,
		reg_ns8,
		reg_s8,
		reg_none
	} slot_reg_t;

	// bus side: waiting for the decode edge, or showing the answer
	typedef enum {
		acc_idle,
		acc_answer
	} acc_state_t;

	// per-unit slot contents
	logic pol7 [num_units];
	logic pol8 [num_units];
	logic [nanos_w-1:0] ns7 [num_units];
	logic [nanos_w-1:0] ns8 [num_units];
	logic [secs_w-1:0] s7 [num_units];
	logic [secs_w-1:0] s8 [num_units];
	logic [phase_w-1:0] ph7 [num_units];

	// per-unit register words as software sees them
	logic [31:0] word_ns7 [num_units];
	logic [31:0] word_s7 [num_units];
	logic [31:0] word_ph7 [num_units];
	logic [31:0] word_ns8 [num_units];
	logic [31:0] word_s8 [num_units];

	// request and decode
	logic rd_req;
	logic wr_req;
	logic req;
	logic sel;
	slot_reg_t reg_pick;
	logic hit;
	logic [31:0] rd_word;

	// access sequencing and answer registers
	acc_state_t acc_q;
	acc_state_t acc_d;
	logic take;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] resp_q;
	logic [1:0] resp_d;

	genvar u;
	generate
		for (u = 0; u < num_units; u++) begin : g_unit
			ts_slot_store ts_slot_store_inst (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.load7(capture7_strobe[u]),
				.load8(capture8_strobe[u]),
				.cap_polarity(capture_polarity),
				.cap_nanos(capture_nanos),
				.cap_secs(capture_secs),
				.cap_phase(capture_phase),
				.seventh_capture_polarity(pol7[u]),
				.seventh_capture_nanos(ns7[u]),
				.seventh_capture_secs(s7[u]),
				.seventh_capture_phase_code(ph7[u]),
				.eighth_capture_polarity(pol8[u]),
				.eighth_capture_nanos(ns8[u]),
				.eighth_capture_secs(s8[u])
			);

			// reserved bit 31 and bits 31:3 tied low here
			assign word_ns7[u] = {1'b0, pol7[u], ns7[u]};
			assign word_s7[u] = s7[u];
			assign word_ph7[u] = {29'h0, ph7[u]};
			assign word_ns8[u] = {1'b0, pol8[u], ns8[u]};
			assign word_s8[u] = s8[u];
		end
	endgenerate

	assign rd_req = avs_read;
	assign wr_req = avs_write;
	assign req = rd_req || wr_req;

	// unit index steers every slot register
	assign sel = unit_index[unit_sel_bit];

	// address decode; anything else is unmapped
	always_comb begin
		reg_pick = reg_none;
		unique case (avs_address)
			sample7_edge_and_nanoseconds_off: reg_pick = reg_ns7;
			sample7_seconds_off: reg_pick = reg_s7;
			sample7_sub_cycle_phase_off: reg_pick = reg_ph7;
			sample8_edge_and_nanoseconds_off: reg_pick = reg_ns8;
			sample8_seconds_off: reg_pick = reg_s8;
			default: reg_pick = reg_none;
		endcase
	end

	assign hit = (reg_pick != reg_none);

	// word of the selected unit
	always_comb begin
		rd_word = unmapped_read;
		unique case (reg_pick)
			reg_ns7: rd_word = word_ns7[sel];
			reg_s7: rd_word = word_s7[sel];
			reg_ph7: rd_word = word_ph7[sel];
			reg_ns8: rd_word = word_ns8[sel];
			reg_s8: rd_word = word_s8[sel];
			reg_none: rd_word = unmapped_read;
		endcase
	end

	// one wait cycle per access, answer on the second
	always_comb begin
		acc_d = acc_q;
		take = 1'b0;
		unique case (acc_q)
			acc_idle: begin
				if (req) begin
					take = 1'b1;
					acc_d = acc_answer;
				end
			end
			acc_answer: begin
				acc_d = acc_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			acc_q <= acc_idle;
		end else begin
			acc_q <= acc_d;
		end
	end

	// answer captured at the decode edge, held until the next access
	always_comb begin
		rdata_d = rdata_q;
		resp_d = resp_q;
		if (take) begin
			rdata_d = unmapped_read;
			resp_d = resp_slverr;
			if (hit) begin
				resp_d = resp_okay;
			end
			if (rd_req) begin
				rdata_d = rd_word;
			end
		end
	end

	// writes earn a response and load unmapped_read into readdata; no slot changes
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rdata_q <= unmapped_read;
			resp_q <= resp_okay;
		end else begin
			rdata_q <= rdata_d;
			resp_q <= resp_d;
		end
	end

	assign avs_waitrequest = req && (acc_q == acc_idle);
	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;
endmodule : ptp_event_sample_slots_7_8
`default_nettype wire

// ===== core/ts_slot_pkg.sv
/*
 * constants for the seventh/eighth event sample slots: register offsets,
 * field positions, reset values.
 * assumes nothing of its surroundings.
 */
package ts_slot_pkg;
	localparam int addr_w = 12;
	localparam logic [11:0] sample7_edge_and_nanoseconds_off = 12'h59c;
	localparam logic [11:0] sample7_seconds_off = 12'h5a0;
	localparam logic [11:0] sample7_sub_cycle_phase_off = 12'h5a4;
	localparam logic [11:0] sample8_edge_and_nanoseconds_off = 12'h5a8;
	localparam logic [11:0] sample8_seconds_off = 12'h5ac;
	localparam int unit_sel_bit = 8;
	localparam int polarity_bit = 30;
	localparam int nanos_w = 30;
	localparam int secs_w = 32;
	localparam int phase_w = 3;
	localparam int num_units = 2;
	localparam logic [29:0] nanos_reset = 30'h0;
	localparam logic [31:0] secs_reset = 32'h0;
	localparam logic [2:0] phase_reset = 3'h0;
	localparam logic [2:0] phase_0ns = 3'h0;
	localparam logic [2:0] phase_8ns = 3'h1;
	localparam logic [2:0] phase_16ns = 3'h5;
	localparam logic [2:0] phase_24ns = 3'h3;
	localparam logic [2:0] phase_32ns = 3'h4;
	localparam logic [31:0] unmapped_read = 32'h0;
endpackage : ts_slot_pkg

// ===== core/ts_slot_store.sv
/*
 * one timestamp unit's pair of sample slots, loaded from the capture logic.
 * assumes capture strobes are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ts_slot_store
	import ts_slot_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic load7,
	input wire logic load8,
	input wire logic cap_polarity,
	input wire logic [ts_slot_pkg::nanos_w-1:0] cap_nanos,
	input wire logic [ts_slot_pkg::secs_w-1:0] cap_secs,
	input wire logic [ts_slot_pkg::phase_w-1:0] cap_phase,
	output logic seventh_capture_polarity,
	output logic [ts_slot_pkg::nanos_w-1:0] seventh_capture_nanos,
	output logic [ts_slot_pkg::secs_w-1:0] seventh_capture_secs,
	output logic [ts_slot_pkg::phase_w-1:0] seventh_capture_phase_code,
	output logic eighth_capture_polarity,
	output logic [ts_slot_pkg::nanos_w-1:0] eighth_capture_nanos,
	output logic [ts_slot_pkg::secs_w-1:0] eighth_capture_secs
);
	import ts_slot_pkg::*;

	logic pol7_q, pol7_d, pol8_q, pol8_d;
	logic [nanos_w-1:0] ns7_q, ns7_d, ns8_q, ns8_d;
	logic [secs_w-1:0] s7_q, s7_d, s8_q, s8_d;
	logic [phase_w-1:0] ph7_q, ph7_d;

	always_comb begin
		pol7_d = pol7_q;
		ns7_d = ns7_q;
		s7_d = s7_q;
		ph7_d = ph7_q;
		pol8_d = pol8_q;
		ns8_d = ns8_q;
		s8_d = s8_q;
		if (load7) begin
			pol7_d = cap_polarity;
			ns7_d = cap_nanos;
			s7_d = cap_secs;
			ph7_d = cap_phase;
		end
		if (load8) begin
			pol8_d = cap_polarity;
			ns8_d = cap_nanos;
			s8_d = cap_secs;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pol7_q <= 1'b0;
			ns7_q <= nanos_reset;
			s7_q <= secs_reset;
			ph7_q <= phase_reset;
			pol8_q <= 1'b0;
			ns8_q <= nanos_reset;
			s8_q <= secs_reset;
		end else begin
			pol7_q <= pol7_d;
			ns7_q <= ns7_d;
			s7_q <= s7_d;
			ph7_q <= ph7_d;
			pol8_q <= pol8_d;
			ns8_q <= ns8_d;
			s8_q <= s8_d;
		end
	end

	assign seventh_capture_polarity = pol7_q;
	assign seventh_capture_nanos = ns7_q;
	assign seventh_capture_secs = s7_q;
	assign seventh_capture_phase_code = ph7_q;
	assign eighth_capture_polarity = pol8_q;
	assign eighth_capture_nanos = ns8_q;
	assign eighth_capture_secs = s8_q;
endmodule : ts_slot_store
`default_nettype wire

// ===== tb/ptp_event_sample_slots_7_8_tb.sv
/* bench for the slot block: captures, then avalon reads from a row table.
   assumes a 100 MHz core clock. */
`timescale 1ns/1ps
`default_nettype none
module ptp_event_sample_slots_7_8_tb;
	import ts_slot_pkg::*;
	logic core_clk = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic avs_waitrequest, capture_polarity = 1'h0;
	logic [11:0] avs_address = 12'h0;
	logic [31:0] avs_readdata, avs_writedata = 32'h0, cs = 32'h0;
	logic [1:0] avs_response, c7 = 2'h0, c8 = 2'h0;
	logic [15:0] unit_index = 16'h0;
	logic [29:0] cn = 30'h0;
	logic [2:0] cp = 3'h0;
	logic [2:0] ph [5] = '{phase_0ns, phase_8ns, phase_16ns, phase_24ns, phase_32ns};
	// unit, address, expected word
	logic [47:0] rows [11] = '{48'h0_59c_3fffffff, 48'h0_5a0_80000001, 48'h0_5a4_00000004,
		48'h0_5a8_52345678, 48'h0_5ac_fedcba98, 48'h1_59c_40000000, 48'h1_5a0_00000002,
		48'h1_5a4_00000001, 48'h1_5a8_00000001, 48'h1_5ac_7fffffff, 48'h0_5b0_00000000};
	int err_count = 0, cmp_count = 0;
	ptp_event_sample_slots_7_8 ptp_event_sample_slots_7_8_inst (.core_clk, .reset_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
		.avs_readdata, .avs_waitrequest, .avs_response, .unit_index, .capture7_strobe(c7),
		.capture8_strobe(c8), .capture_polarity, .capture_nanos(cn), .capture_secs(cs),
		.capture_phase(cp));
	initial forever #5 core_clk = ~core_clk;
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task stop_test;
		if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// one avalon access; request held until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [11:0] a, input logic [31:0] e);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= 32'hffffffff;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'h0);
		chk({avs_waitrequest, avs_response, 29'h0}, {1'h0, {2{a == 12'h5b0}}, 29'h0});
		if (!w) chk(avs_readdata, e);
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge core_clk);
	endtask : bus
	task cap(input logic [3:0] st, input logic p, input logic [29:0] n, input logic [31:0] s,
		input logic [2:0] c);
		{c8, c7} <= st;
		capture_polarity <= p;
		cn <= n;
		cs <= s;
		cp <= c;
		@(posedge core_clk);
		{c8, c7} <= 4'h0;
		@(posedge core_clk);
	endtask : cap
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'h1;
		@(posedge core_clk);
		for (int i = 0; i < 5; i++) bus(1'h0, rows[i][43:32], 32'h0);
		cap(4'h1, 1'h0, 30'h3fffffff, 32'h80000001, 3'h4);
		cap(4'h4, 1'h1, 30'h12345678, 32'hfedcba98, 3'h0);
		cap(4'h2, 1'h1, 30'h0, 32'h2, 3'h1);
		cap(4'h8, 1'h0, 30'h1, 32'h7fffffff, 3'h0);
		for (int i = 0; i < 11; i++) begin
			unit_index <= rows[i][44] ? 16'h0100 : 16'hfeff;
			bus(1'h0, rows[i][43:32], rows[i][31:0]);
		end
		bus(1'h1, 12'h59c, 32'h0);
		bus(1'h0, 12'h59c, 32'h3fffffff);
		for (int i = 0; i < 5; i++) begin
			cap(4'h1, 1'h0, 30'h0, 32'h0, ph[i]);
			bus(1'h0, 12'h5a4, {29'h0, ph[i]});
		end
		stop_test;
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		stop_test;
	end
endmodule : ptp_event_sample_slots_7_8_tb
`default_nettype wire

// ===== tb/slots_properties.sv
/* assertions on the slot block's avalon slave port.
   bound to ptp_event_sample_slots_7_8, one clock. */
`timescale 1ns/1ps
`default_nettype none
module slots_properties (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] avs_response
);
	wire ack = avs_read & ~avs_waitrequest;
	wire fin = (avs_read | avs_write) & ~avs_waitrequest;
	wire hit = avs_address inside {12'h59c, 12'h5a0, 12'h5a4, 12'h5a8, 12'h5ac};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_wait1; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait1: assert property (p_wait1) else $error("bad wait");
	property p_rise; $rose(avs_read) |-> avs_waitrequest; endproperty
	a_rise: assert property (p_rise) else $error("no wait");
	property p_unmap; ack && !hit |-> avs_response == 2'h3 && avs_readdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_ok; fin && hit |-> avs_response == 2'h0; endproperty
	a_ok: assert property (p_ok) else $error("bad response");
	property p_b31;
		ack && (avs_address == 12'h59c || avs_address == 12'h5a8) |-> !avs_readdata[31];
	endproperty
	a_b31: assert property (p_b31) else $error("bit 31 set");
	property p_ph; ack && avs_address == 12'h5a4 |-> avs_readdata[31:3] == 29'h0; endproperty
	a_ph: assert property (p_ph) else $error("phase high bits");
	property p_rd_hold; $changed(avs_readdata) |-> fin; endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
	property p_rsp_hold; $changed(avs_response) |-> fin; endproperty
	a_rsp_hold: assert property (p_rsp_hold) else $error("response moved");
endmodule : slots_properties
bind ptp_event_sample_slots_7_8 slots_properties slots_properties_inst (.core_clk, .reset_n,
	.avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response);
`default_nettype wire
